/* onchip_osc_freq_and_source_ctrl.sv */
// Behaviour
// R1: reset loads divider from boot option bits
// R2: divider code to frequency, range-bit dependent
// R3: divider register 8-bit, upper bits zero
// R4: software changes divider on fast clock only
// R5: three old clocks, three held clocks
// R6: software keeps frequency inside flash range
// R7: six-bit monotonic trim, bits 7:6 zero
// R8: trim resets to factory calibration value
// R9: mode 0,1 runs resonator oscillator
// R10: mode 1,1 takes external clock pin
// R11: mode 0,0 leaves pins as ports
// R12: fast oscillator starts after reset release
// R13: status bit 0 starts/stops fast oscillator
// R14: slow oscillator feeds watchdog only
// R15: slow oscillator runs when watchdog enabled
// R16: standby stops slow oscillator unless allowed
// R17: software cannot stop running slow oscillator
// R18: boot base frequency from seven choices
// R19: four option bits decode base frequency
// R20: glitch-free switch via clock hold
`timescale 1ns/1ps
`include "osc_ctrl_consts.svh"
module onchip_osc_freq_and_source_ctrl
(
  // clock, reset, enable
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  // register access port
  input wire logic [19:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  output logic [7:0] o_sfr_rdata,
  // boot option bytes and factory trim
  input wire logic [7:0] i_opt_clock_byte,
  input wire logic [7:0] i_opt_wdt_byte,
  input wire logic [5:0] i_trim_factory,
  // control bits and system state
  input wire logic [1:0] i_clock_mode_control,
  input wire logic i_fast_internal_osc_halt,
  input wire logic i_fast_osc_is_cpu_clk,
  input wire logic i_standby,
  // fast oscillator
  output logic o_fast_osc_run,
  output logic [5:0] o_fast_osc_mhz,
  output logic [5:0] o_fast_osc_trim,
  output logic o_cpu_clk_hold,
  output logic o_flash_range_err,
  output logic o_boot_code_bad,
  // main oscillator
  output logic o_main_res_run,
  output logic o_main_ext_clk,
  output logic o_main_pins_port,
  // slow oscillator
  output logic o_slow_osc_run,
  output logic o_slow_osc_cpu_sel
);

  ////////////////////////////////////////////////////////////////////////
  // decode functions

  // divider code to mhz, zero when prohibited
  function automatic osc_ctrl_pkg::mhz_t div_mhz(input logic range, input logic [2:0] code);
    osc_ctrl_pkg::mhz_t f;
    f = 6'h00;
    case ({range, code})
      4'h0: f = 6'h18;
      4'h1: f = 6'h0C;
      4'h2: f = 6'h06;
      4'h3: f = 6'h03;
      4'h8: f = 6'h20;
      4'h9: f = 6'h10;
      4'hA: f = 6'h08;
      4'hB: f = 6'h04;
      4'hC: f = 6'h02;
      4'hD: f = 6'h01;
      default: f = 6'h00;
    endcase
    return f;
  endfunction

  // base option bits to mhz, zero when prohibited
  // R18: seven boot choices
  function automatic osc_ctrl_pkg::mhz_t base_mhz(input logic [3:0] code);
    osc_ctrl_pkg::mhz_t f;
    f = 6'h00;
    case (code)
      4'h8: f = 6'h20;
      4'h0: f = 6'h18;
      4'h9: f = 6'h10;
      4'h1: f = 6'h0C;
      4'hA: f = 6'h08;
      4'hB: f = 6'h04;
      4'hD: f = 6'h01;
      default: f = 6'h00;
    endcase
    return f;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state

  logic boot_done_r, boot_done_nxt; // option bytes captured
  logic [2:0] div_sel_r, div_sel_nxt; // software-visible divider
  logic [2:0] div_act_r, div_act_nxt; // divider driving the oscillator
  logic [2:0] div_pend_r, div_pend_nxt; // divider awaiting switch
  logic [5:0] trim_r, trim_nxt; // trim field
  logic [1:0] cnt_r, cnt_nxt; // transition cycle counter
  osc_ctrl_pkg::switch_state_e st_r, st_nxt;
  logic [7:0] rdata_r, rdata_nxt; // read data
  logic range_err_r, range_err_nxt; // flash range flag
  logic boot_bad_r, boot_bad_nxt; // prohibited base code seen
  logic [5:0] mhz_r, mhz_nxt; // applied frequency
  logic range_bit; // base range option bit
  logic wr_div, wr_trim, div_ok;
  logic [5:0] lim_mhz; // flash mode upper limit

  assign range_bit = i_opt_clock_byte[`BASE_RANGE_BIT];
  assign wr_div = i_sfr_wr && (i_sfr_addr == `DIV_ADDR);
  assign wr_trim = i_sfr_wr && (i_sfr_addr == `TRIM_ADDR);
  // high-speed flash mode lifts the limit
  assign lim_mhz = i_opt_clock_byte[`FLASH_MODE0_BIT] ? `FLASH_HS_MAX_MHZ : `FLASH_LS_MAX_MHZ;

  ////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb
  begin
    boot_done_nxt = boot_done_r;
    div_sel_nxt = div_sel_r;
    div_act_nxt = div_act_r;
    div_pend_nxt = div_pend_r;
    trim_nxt = trim_r;
    cnt_nxt = cnt_r;
    st_nxt = st_r;
    rdata_nxt = rdata_r;
    boot_bad_nxt = boot_bad_r;
    // divider writes need a valid code, the fast clock, and an idle switch
    // R4: fast clock gate
    div_ok = (div_mhz(range_bit, i_sfr_wdata[2:0]) != 6'h00) && i_fast_osc_is_cpu_clk
      && (st_r == osc_ctrl_pkg::SW_IDLE);
    if (!boot_done_r)
    begin
      // R1: boot load
      boot_done_nxt = 1'b1;
      div_sel_nxt = i_opt_clock_byte[2:0];
      div_act_nxt = i_opt_clock_byte[2:0];
      // R19: base decode check
      boot_bad_nxt = (base_mhz(i_opt_clock_byte[3:0]) == 6'h00);
      // R8: factory trim
      trim_nxt = i_trim_factory;
    end
    else
    begin
      // R3: divider byte write
      if (wr_div && div_ok)
      begin
        div_sel_nxt = i_sfr_wdata[2:0];
        div_pend_nxt = i_sfr_wdata[2:0];
        cnt_nxt = 2'h1;
        st_nxt = osc_ctrl_pkg::SW_OLD;
      end
      // R7: six-bit trim
      if (wr_trim)
      begin
        trim_nxt = i_sfr_wdata[5:0];
      end
      // R5: transition sequence
      case (st_r)
        osc_ctrl_pkg::SW_IDLE:
        begin
        end
        osc_ctrl_pkg::SW_OLD:
        begin
          // still on the old frequency
          if (cnt_r == `SWITCH_OLD_CLKS)
          begin
            cnt_nxt = 2'h1;
            st_nxt = osc_ctrl_pkg::SW_HOLD;
          end
          else
          begin
            cnt_nxt = cnt_r + 2'h1;
          end
        end
        osc_ctrl_pkg::SW_HOLD:
        begin
          // R20: swap only while clock is held
          if (cnt_r == `SWITCH_HOLD_CLKS)
          begin
            div_act_nxt = div_pend_r;
            cnt_nxt = 2'h0;
            st_nxt = osc_ctrl_pkg::SW_IDLE;
          end
          else
          begin
            cnt_nxt = cnt_r + 2'h1;
          end
        end
        default:
        begin
          st_nxt = osc_ctrl_pkg::SW_IDLE;
        end
      endcase
    end
    // register read, reserved bits zero
    if (i_sfr_rd)
    begin
      if (i_sfr_addr == `DIV_ADDR)
      begin
        rdata_nxt = {5'h00, div_sel_r};
      end
      else if (i_sfr_addr == `TRIM_ADDR)
      begin
        rdata_nxt = {2'h0, trim_r};
      end
      else
      begin
        rdata_nxt = 8'h00;
      end
    end
    // R2: frequency of applied code
    mhz_nxt = div_mhz(range_bit, div_act_nxt);
    // R6: flag frequency outside flash range
    range_err_nxt = !i_opt_clock_byte[`FLASH_MODE1_BIT] || (mhz_nxt < `FLASH_MIN_MHZ)
      || (mhz_nxt > lim_mhz);
  end

  // registers only
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      boot_done_r <= 1'b0;
      div_sel_r <= `DIV_RST;
      div_act_r <= `DIV_RST;
      div_pend_r <= `DIV_RST;
      trim_r <= `TRIM_RST;
      cnt_r <= 2'h0;
      st_r <= osc_ctrl_pkg::SW_IDLE;
      rdata_r <= 8'h00;
      range_err_r <= 1'b0;
      boot_bad_r <= 1'b0;
      mhz_r <= 6'h00;
    end
    else if (i_clk_en)
    begin
      boot_done_r <= boot_done_nxt;
      div_sel_r <= div_sel_nxt;
      div_act_r <= div_act_nxt;
      div_pend_r <= div_pend_nxt;
      trim_r <= trim_nxt;
      cnt_r <= cnt_nxt;
      st_r <= st_nxt;
      rdata_r <= rdata_nxt;
      range_err_r <= range_err_nxt;
      boot_bad_r <= boot_bad_nxt;
      mhz_r <= mhz_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign o_sfr_rdata = rdata_r;
  assign o_fast_osc_mhz = mhz_r;
  assign o_fast_osc_trim = trim_r;
  assign o_flash_range_err = range_err_r;
  assign o_boot_code_bad = boot_bad_r;
  // R20: hold the cpu clock across the swap
  assign o_cpu_clk_hold = (st_r == osc_ctrl_pkg::SW_HOLD);
  // R12: runs from release unless halted
  // R13: halt bit stops it
  assign o_fast_osc_run = boot_done_r && !i_fast_internal_osc_halt;
  // R9: resonator mode
  assign o_main_res_run = !i_clock_mode_control[`EXT_CLK_SEL_BIT]
    && i_clock_mode_control[`OSC_SEL_BIT];
  // R10: external clock mode
  assign o_main_ext_clk = i_clock_mode_control[`EXT_CLK_SEL_BIT]
    && i_clock_mode_control[`OSC_SEL_BIT];
  // R11: pins left as ports
  assign o_main_pins_port = (i_clock_mode_control == 2'h0);
  // R15: watchdog enable runs it
  // R16: standby stop unless allowed
  // R17: no software input here
  assign o_slow_osc_run = i_opt_wdt_byte[`WDT_EN_BIT]
    && !(i_standby && !i_opt_wdt_byte[`WDT_STBY_BIT]);
  // R14: never a cpu clock choice
  assign o_slow_osc_cpu_sel = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // checks
  boot_load_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R1
    (i_rst_n && !boot_done_r && i_clk_en) |=> (div_sel_r == $past(i_opt_clock_byte[2:0])))
    else $error("divider not loaded from option byte");
  old_phase_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R5
    (st_r == osc_ctrl_pkg::SW_IDLE && boot_done_r && i_clk_en && wr_div && div_ok)
    ##1 i_clk_en [*3] |=> (st_r == osc_ctrl_pkg::SW_HOLD && div_act_r == $past(div_act_r, 4)))
    else $error("old-frequency phase wrong length");
  hold_apply_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R20
    (st_r == osc_ctrl_pkg::SW_HOLD && cnt_r == 2'h3 && i_clk_en)
    |=> (div_act_r == div_pend_r && !o_cpu_clk_hold))
    else $error("divider not applied at end of hold");
  act_stable_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R20
    (boot_done_r && !$past(o_cpu_clk_hold) && $past(boot_done_r)) |-> $stable(div_act_r))
    else $error("divider changed outside hold");
  fast_gate_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R4
    (boot_done_r && i_clk_en && wr_div && !i_fast_osc_is_cpu_clk) |=> $stable(div_sel_r))
    else $error("divider written off the fast clock");
  div_read_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R3
    (i_clk_en && i_sfr_rd && i_sfr_addr == `DIV_ADDR) |=> (o_sfr_rdata[7:3] == 5'h00))
    else $error("divider upper bits not zero");
  trim_write_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R7
    (boot_done_r && i_clk_en && wr_trim) |=> (o_fast_osc_trim == $past(i_sfr_wdata[5:0])))
    else $error("trim write lost");
  freq_map_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R2
    (boot_done_r && i_clk_en) |=> (o_fast_osc_mhz == div_mhz(range_bit, div_act_r)))
    else $error("frequency map mismatch");
  slow_src_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R14
    !o_slow_osc_cpu_sel ##1 (o_slow_osc_run == (i_opt_wdt_byte[`WDT_EN_BIT]
    && !(i_standby && !i_opt_wdt_byte[`WDT_STBY_BIT]))))
    else $error("slow oscillator misused");
  mode_excl_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R11
    $onehot0({o_main_res_run, o_main_ext_clk, o_main_pins_port}))
    else $error("main oscillator modes overlap");
  switch_c: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    st_r == osc_ctrl_pkg::SW_HOLD ##1 st_r == osc_ctrl_pkg::SW_IDLE);
  trim_c: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    boot_done_r && wr_trim && i_clk_en);
  refuse_c: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    boot_done_r && wr_div && !div_ok && i_clk_en);
  range_c: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) o_flash_range_err);

endmodule

/* osc_ctrl_consts.svh */
`ifndef OSC_CTRL_CONSTS_SVH
`define OSC_CTRL_CONSTS_SVH
// register byte addresses
`define TRIM_ADDR 20'hF00A0
`define DIV_ADDR 20'hF00A8
// field widths
`define DIV_W 3
`define TRIM_W 6
// clock option byte fields
`define BASE_RANGE_BIT 3
`define FLASH_MODE1_BIT 7
`define FLASH_MODE0_BIT 6
// watchdog option byte fields
`define WDT_EN_BIT 4
`define WDT_STBY_BIT 0
// clock mode control fields
`define EXT_CLK_SEL_BIT 1
`define OSC_SEL_BIT 0
// reset values before the boot load
`define DIV_RST 3'h0
`define TRIM_RST 6'h00
// switch transition lengths in cycles
`define SWITCH_OLD_CLKS 2'h3
`define SWITCH_HOLD_CLKS 2'h3
// flash mode frequency limits in mhz
`define FLASH_MIN_MHZ 6'h01
`define FLASH_LS_MAX_MHZ 6'h08
`define FLASH_HS_MAX_MHZ 6'h20
`endif

/* osc_ctrl_pkg.sv */
package osc_ctrl_pkg;
  // divider switch sequence states
  typedef enum logic [1:0] {SW_IDLE, SW_OLD, SW_HOLD} switch_state_e;
  // frequency in whole mhz, zero for a prohibited code
  typedef logic [5:0] mhz_t;
endpackage

/* tb.sv */
`timescale 1ns/1ps
`include "osc_ctrl_consts.svh"
module tb;
  // clock, reset and stimulus
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_clk_en = 1'b1;
  logic [19:0] i_sfr_addr = 20'h00000;
  logic [7:0] i_sfr_wdata = 8'h00;
  logic i_sfr_wr = 1'b0;
  logic i_sfr_rd = 1'b0;
  logic [7:0] i_opt_clock_byte = 8'hC9;
  logic [7:0] i_opt_wdt_byte = 8'h00;
  logic [5:0] i_trim_factory = 6'h2A;
  logic [1:0] i_clock_mode_control = 2'h0;
  logic i_fast_internal_osc_halt = 1'b0;
  logic i_fast_osc_is_cpu_clk = 1'b1;
  logic i_standby = 1'b0;
  // design outputs
  logic [7:0] o_sfr_rdata;
  logic o_fast_osc_run;
  logic [5:0] o_fast_osc_mhz;
  logic [5:0] o_fast_osc_trim;
  logic o_cpu_clk_hold;
  logic o_flash_range_err;
  logic o_boot_code_bad;
  logic o_main_res_run;
  logic o_main_ext_clk;
  logic o_main_pins_port;
  logic o_slow_osc_run;
  logic o_slow_osc_cpu_sel;
  // bookkeeping
  int num_errors = 0;
  int n_compared = 0;
  logic [7:0] rdat;

  onchip_osc_freq_and_source_ctrl onchip_osc_freq_and_source_ctrl_inst
  (
    .i_sys_clk, .i_rst_n, .i_clk_en, .i_sfr_addr, .i_sfr_wdata, .i_sfr_wr, .i_sfr_rd,
    .o_sfr_rdata, .i_opt_clock_byte, .i_opt_wdt_byte, .i_trim_factory,
    .i_clock_mode_control, .i_fast_internal_osc_halt, .i_fast_osc_is_cpu_clk, .i_standby,
    .o_fast_osc_run, .o_fast_osc_mhz, .o_fast_osc_trim, .o_cpu_clk_hold,
    .o_flash_range_err, .o_boot_code_bad, .o_main_res_run, .o_main_ext_clk,
    .o_main_pins_port, .o_slow_osc_run, .o_slow_osc_cpu_sel
  );

  ////////////////////////////////////////////////////////////////////////////
  // 25 mhz clock
  always #20 i_sys_clk = ~i_sys_clk;

  // hang guard
  initial
  begin
    #400000;
    num_errors++;
    stop_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare any value, zero-extended to a byte
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // counts and verdict
  task stop_test();
    $display("compared=%0d errors=%0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // reset for 17 cycles with a given clock option byte
  task boot(input logic [7:0] cb);
    @(posedge i_sys_clk);
    i_rst_n <= 1'b0;
    i_opt_clock_byte <= cb;
    repeat (16) @(posedge i_sys_clk);
    #1;
    chk({2'h0, o_fast_osc_mhz}, 8'h00);
    @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    #1;
  endtask

  // one-strobe register write
  task wr(input logic [19:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_sfr_addr <= a;
    i_sfr_wdata <= d;
    i_sfr_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_sfr_wr <= 1'b0;
  endtask

  // one-strobe register read
  task rd(input logic [19:0] a, output logic [7:0] d);
    @(posedge i_sys_clk);
    i_sfr_addr <= a;
    i_sfr_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_sfr_rd <= 1'b0;
    @(posedge i_sys_clk);
    #1;
    d = o_sfr_rdata;
  endtask

  // divider write, then count held cycles and check the applied rate
  task div_set(input logic [2:0] code, input logic [7:0] mhz);
    int holds;
    holds = 0;
    wr(`DIV_ADDR, {5'h00, code});
    repeat (10)
    begin
      @(posedge i_sys_clk);
      #1;
      if (o_cpu_clk_hold === 1'b1)
        holds++;
    end
    chk(holds[7:0], 8'h03);
    chk({2'h0, o_fast_osc_mhz}, mhz);
  endtask

  // divider write that must be refused
  task div_refused(input logic [2:0] code, input logic [7:0] keep);
    wr(`DIV_ADDR, {5'h00, code});
    repeat (10) @(posedge i_sys_clk);
    rd(`DIV_ADDR, rdat);
    chk(rdat, keep);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    // every base option code at boot
    for (int c = 0; c < 16; c++)
    begin
      boot({4'hC, c[3:0]});
      chk({7'h00, o_boot_code_bad}, {7'h00, !(16'h2F03 >> c & 1)});
      if (16'h2F03 >> c & 1)
        chk({2'h0, o_fast_osc_mhz}, (c[3] ? 8'h20 : 8'h18) >> c[2:0]);
    end
    boot(8'hC9);
    rd(`DIV_ADDR, rdat);
    chk(rdat, 8'h01);
    rd(`TRIM_ADDR, rdat);
    chk(rdat, 8'h2A);
    chk({7'h00, o_fast_osc_run}, 8'h01);
    // range bit 1 divider table
    for (int i = 0; i < 6; i++)
      div_set(i[2:0], 8'h20 >> i);
    chk({7'h00, o_flash_range_err}, 8'h00);
    div_refused(3'h6, 8'h05);
    div_refused(3'h7, 8'h05);
    // divider write while another clock drives the cpu
    @(posedge i_sys_clk);
    i_fast_osc_is_cpu_clk <= 1'b0;
    div_refused(3'h0, 8'h05);
    @(posedge i_sys_clk);
    i_fast_osc_is_cpu_clk <= 1'b1;
    // trim width and unmapped read
    wr(`TRIM_ADDR, 8'hFF);
    rd(`TRIM_ADDR, rdat);
    chk(rdat, 8'h3F);
    chk({2'h0, o_fast_osc_trim}, 8'h3F);
    wr(`TRIM_ADDR, 8'h00);
    rd(20'hF00A4, rdat);
    chk(rdat, 8'h00);
    chk({2'h0, o_fast_osc_trim}, 8'h00);
    // frozen edges drop a trim write
    @(posedge i_sys_clk);
    i_clk_en <= 1'b0;
    wr(`TRIM_ADDR, 8'h15);
    @(posedge i_sys_clk);
    i_clk_en <= 1'b1;
    #1;
    chk({2'h0, o_fast_osc_trim}, 8'h00);
    // main oscillator modes
    for (int m = 0; m < 4; m++)
    begin
      @(posedge i_sys_clk);
      i_clock_mode_control <= m[1:0];
      #1;
      chk({5'h00, o_main_res_run, o_main_ext_clk, o_main_pins_port},
          {5'h00, m == 1, m == 3, m == 0});
    end
    // fast oscillator stop and restart
    @(posedge i_sys_clk);
    i_fast_internal_osc_halt <= 1'b1;
    #1;
    chk({7'h00, o_fast_osc_run}, 8'h00);
    @(posedge i_sys_clk);
    i_fast_internal_osc_halt <= 1'b0;
    #1;
    chk({7'h00, o_fast_osc_run}, 8'h01);
    // slow oscillator: enable, standby-run, standby
    for (int k = 0; k < 8; k++)
    begin
      @(posedge i_sys_clk);
      i_opt_wdt_byte <= {3'h0, k[2], 3'h0, k[1]};
      i_standby <= k[0];
      i_fast_internal_osc_halt <= k[0];
      #1;
      chk({7'h00, o_slow_osc_run}, {7'h00, k[2] & !(k[0] & !k[1])});
      chk({7'h00, o_slow_osc_cpu_sel}, 8'h00);
    end
    // low speed flash mode at 32 mhz, then into range
    boot(8'h88);
    chk({7'h00, o_flash_range_err}, 8'h01);
    div_set(3'h2, 8'h08);
    chk({7'h00, o_flash_range_err}, 8'h00);
    // range bit 0 divider table
    boot(8'hC0);
    for (int i = 0; i < 4; i++)
      div_set(i[2:0], 8'h18 >> i);
    div_refused(3'h4, 8'h03);
    // prohibited flash mode is flagged
    boot(8'h48);
    chk({7'h00, o_flash_range_err}, 8'h01);
    stop_test();
  end
endmodule
